// ---- design/status_irq_pkg.sv ----
package status_irq_pkg;

  // Avalon byte address width and data width of the register slave.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // Byte offsets of the registers, one aligned word each.
  localparam logic [4:0] OFS_LIVE = 5'h00;
  localparam logic [4:0] OFS_STICKY = 5'h04;
  localparam logic [4:0] OFS_CLEAR = 5'h08;
  localparam logic [4:0] OFS_IRQ_EN = 5'h0c;
  localparam logic [4:0] OFS_MODE = 5'h10;

  // Number of conditions that own a sticky bit and an enable bit.
  localparam int NUM_SRC = 6;

  // Bit positions shared by the live, sticky, clear and enable layouts.
  localparam int SRC_REF0 = 0;
  localparam int SRC_REF1 = 1;
  localparam int SRC_PLL1 = 2;
  localparam int SRC_PLL2 = 3;
  localparam int SRC_HOLD = 4;
  localparam int SRC_REFV = 5;

  // Live-only bits that sit above the sticky sources.
  localparam int LIVE_VCO = 6;
  localparam int LIVE_SEL = 7;
  localparam int LIVE_W = 8;

  // Positions of the pin inputs inside the synchroniser vector.
  localparam int PIN_REF0 = 0;
  localparam int PIN_REF1 = 1;
  localparam int PIN_PLL1 = 2;
  localparam int PIN_PLL2 = 3;
  localparam int PIN_HOLD = 4;
  localparam int PIN_CALDONE = 5;
  localparam int PIN_SEL = 6;
  localparam int PIN_BUSY = 7;
  localparam int SYNC_W = 8;

  // Field of the selection mode register.
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;

  // Reference selection modes that shape the reference-valid bit.
  typedef enum logic [1:0] {
    SEL_MANUAL,
    SEL_SHORT_HOLD,
    SEL_AUTO,
    SEL_AUTO_HOLD
  } sel_mode_t;

  // Reset values.
  localparam logic [NUM_SRC-1:0] IRQ_EN_RESET = 6'h00;
  localparam logic [NUM_SRC-1:0] STICKY_RESET = 6'h00;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

endpackage : status_irq_pkg

// ---- design/sticky_if.sv ----
// Carries fault events, clears and enables to the sticky bank and brings
// the latched bits and the combined pending flag back.
interface sticky_if;
  logic [status_irq_pkg::NUM_SRC-1:0] fault;
  logic [status_irq_pkg::NUM_SRC-1:0] clr;
  logic [status_irq_pkg::NUM_SRC-1:0] en;
  logic [status_irq_pkg::NUM_SRC-1:0] sticky;
  logic pending;

  modport bank (
    input fault,
    input clr,
    input en,
    output sticky,
    output pending
  );

  modport ctrl (
    output fault,
    output clr,
    output en,
    input sticky,
    input pending
  );
endinterface : sticky_if

// ---- design/pin_sync.sv ----
// Two-stage synchroniser for the asynchronous status pins.
module pin_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [status_irq_pkg::SYNC_W-1:0] pins,
  output logic [status_irq_pkg::SYNC_W-1:0] synced
);

  // Both stages live in one state record.
  typedef struct packed {
    logic [status_irq_pkg::SYNC_W-1:0] meta;
    logic [status_irq_pkg::SYNC_W-1:0] stable;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;

  // The first stage is read only by the second stage.
  always_comb begin
    s_next.meta = pins;
    s_next.stable = s_reg.meta;
  end

  // Both stages clear to a constant on reset.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg.meta <= status_irq_pkg::SYNC_RESET;
      s_reg.stable <= status_irq_pkg::SYNC_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign synced = s_reg.stable;

endmodule : pin_sync

// ---- design/sticky_bank.sv ----
// Latched fault bits with write-one-to-clear and enable masking.
module sticky_bank (
  input wire logic clk_sys,
  input wire logic rst,
  sticky_if.bank port
);

  // The whole bank is one record of latched fault bits.
  typedef struct packed {
    logic [status_irq_pkg::NUM_SRC-1:0] sticky;
  } bank_state_t;

  bank_state_t s_reg;
  bank_state_t s_next;

  // A fault present in the clear cycle wins, so no event is lost and a
  // persisting fault re-sets its bit at once.
  always_comb begin
    s_next.sticky = (s_reg.sticky & ~port.clr) | port.fault; // (R2) (R3)
  end

  // Latched faults start empty after reset.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg.sticky <= status_irq_pkg::STICKY_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign port.sticky = s_reg.sticky;
  // Only enabled latched faults count; all enables low means no pending.
  assign port.pending = |(s_reg.sticky & port.en); // (R4) (R5) (R16)

endmodule : sticky_bank

// ---- design/status_irq_top.sv ----
// Notes on behaviour
// (R1) Live bits read current condition, never latched.
// (R2) Sticky bit set by event, write one clears.
// (R3) Clear fails while condition persists; bit re-sets.
// (R4) Enable zero masks sticky bit from interrupt.
// (R5) All enables zero: interrupt never asserts.
// (R6) Interrupt releases once enabled stickies are cleared.
// (R7) Both inputs: live, sticky, enable; 1 active.
// (R8) Lock and holdover bits active low, sticky, enable.
// (R9) Calibration bit live only, 1 while pending.
// (R10) Selection bit live only, 0 input0, 1 input1.
// (R11) Manual modes: ref-valid 0 when selected lost.
// (R12) Auto mode: ref-valid 0 while lost or selecting.
// (R13) Auto-holdover mode: ref-valid 0 while lost, holdover.
// (R14) Lock pin 1 only when both sticky locked.
// (R15) Software enables both lock-loss interrupts for both.
// (R16) Any enabled sticky set raises the interrupt.
// (R17) Second PLL lock loss: live, sticky, pin, interrupt.
// (R18) Interrupt output active low, level held.
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
module status_irq_top (
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave port.
  input wire logic [status_irq_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [status_irq_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [status_irq_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // Asynchronous condition pins from the clocking core.
  input wire logic ref_in0_sense,
  input wire logic ref_in1_sense,
  input wire logic pll1_lock_sense,
  input wire logic pll2_lock_sense,
  input wire logic holdover_sense,
  input wire logic vco_cal_done_sense,
  input wire logic ref_sel_sense,
  input wire logic sel_busy_sense,
  // Device pins.
  output logic irq_out_n,
  output logic lock_out
);

  // All control state of the top level in one record.
  typedef struct packed {
    logic wait_req;
    logic [status_irq_pkg::DATA_W-1:0] rdata;
    logic [status_irq_pkg::NUM_SRC-1:0] irq_en;
    status_irq_pkg::sel_mode_t mode;
    logic irq_n;
    logic lock;
  } top_state_t;

  top_state_t s_reg;
  top_state_t s_next;

  // Raw and synchronised copies of the condition pins.
  logic [status_irq_pkg::SYNC_W-1:0] pin_vec;
  logic [status_irq_pkg::SYNC_W-1:0] pin_s;

  // Named views of the synchronised pins.
  logic ref_in0_live;
  logic ref_in1_live;
  logic pll1_locked_live_n;
  logic pll2_locked_live_n;
  logic holdover_live_n;
  logic vco_cal_pending;
  logic selected_input_live;
  logic sel_busy;

  // Derived reference-valid level and the assembled live word.
  logic selected_active;
  logic ref_valid_live;
  logic [status_irq_pkg::LIVE_W-1:0] live_word;

  // Bus decode helpers.
  logic accept;
  logic commit_wr;
  logic lane0;

  // Link to the sticky bank.
  sticky_if sif ();

  // Gather the pins into one vector for the synchroniser.
  always_comb begin
    pin_vec = '0;
    pin_vec[status_irq_pkg::PIN_REF0] = ref_in0_sense;
    pin_vec[status_irq_pkg::PIN_REF1] = ref_in1_sense;
    pin_vec[status_irq_pkg::PIN_PLL1] = pll1_lock_sense;
    pin_vec[status_irq_pkg::PIN_PLL2] = pll2_lock_sense;
    pin_vec[status_irq_pkg::PIN_HOLD] = holdover_sense;
    pin_vec[status_irq_pkg::PIN_CALDONE] = vco_cal_done_sense;
    pin_vec[status_irq_pkg::PIN_SEL] = ref_sel_sense;
    pin_vec[status_irq_pkg::PIN_BUSY] = sel_busy_sense;
  end

  // Every pin comes from the analog core's own timing, so all pass
  // two flip-flops before any logic here looks at them.
  pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pins(pin_vec),
    .synced(pin_s)
  );

  // Live conditions; the reference, lock and holdover views read 1 as the healthy value.
  always_comb begin
    ref_in0_live = pin_s[status_irq_pkg::PIN_REF0]; // (R7)
    ref_in1_live = pin_s[status_irq_pkg::PIN_REF1]; // (R7)
    pll1_locked_live_n = pin_s[status_irq_pkg::PIN_PLL1]; // (R8)
    pll2_locked_live_n = pin_s[status_irq_pkg::PIN_PLL2]; // (R8) (R17)
    holdover_live_n = ~pin_s[status_irq_pkg::PIN_HOLD]; // (R8)
    vco_cal_pending = ~pin_s[status_irq_pkg::PIN_CALDONE]; // (R9)
    selected_input_live = pin_s[status_irq_pkg::PIN_SEL]; // (R10)
    sel_busy = pin_s[status_irq_pkg::PIN_BUSY];
  end

  // The reference-valid level depends on the selection mode that
  // software programmed, because the manual, auto and auto-holdover modes define loss differently.
  always_comb begin
    // Activity of whichever input is selected right now.
    selected_active = selected_input_live ? ref_in1_live : ref_in0_live;
    case (s_reg.mode)
      status_irq_pkg::SEL_MANUAL,
      status_irq_pkg::SEL_SHORT_HOLD: begin
        // Valid exactly while the selected input is present.
        ref_valid_live = selected_active; // (R11)
      end
      status_irq_pkg::SEL_AUTO: begin
        // Low while lost and while priority selection is running.
        ref_valid_live = selected_active & ~sel_busy; // (R12)
      end
      status_irq_pkg::SEL_AUTO_HOLD: begin
        // Low while lost and while the device still sits in holdover.
        ref_valid_live = selected_active & holdover_live_n; // (R13)
      end
      default: begin
        ref_valid_live = selected_active;
      end
    endcase
  end

  // Assemble the live word and the fault vector for the sticky bank.
  always_comb begin
    live_word = '0;
    live_word[status_irq_pkg::SRC_REF0] = ref_in0_live;
    live_word[status_irq_pkg::SRC_REF1] = ref_in1_live;
    live_word[status_irq_pkg::SRC_PLL1] = pll1_locked_live_n;
    live_word[status_irq_pkg::SRC_PLL2] = pll2_locked_live_n;
    live_word[status_irq_pkg::SRC_HOLD] = holdover_live_n;
    live_word[status_irq_pkg::SRC_REFV] = ref_valid_live;
    live_word[status_irq_pkg::LIVE_VCO] = vco_cal_pending;
    live_word[status_irq_pkg::LIVE_SEL] = selected_input_live;
  end

  // A fault is a healthy bit gone low; the bank latches it.
  assign sif.fault = ~live_word[status_irq_pkg::NUM_SRC-1:0]; // (R2)
  assign sif.en = s_reg.irq_en;

  // The bank holds the latched faults and their masked pending flag.
  sticky_bank u_bank (
    .clk_sys(clk_sys),
    .rst(rst),
    .port(sif.bank)
  );

  // A request is taken on the first edge it is seen with waitrequest
  // high; the answer cycle follows with waitrequest low. Writes commit
  // on the edge the master sees waitrequest low, so each write acts
  // exactly once even though the master holds it for two cycles.
  assign accept = (read | write) & s_reg.wait_req;
  assign commit_wr = write & ~s_reg.wait_req;
  // Every field sits in the low byte, so only that lane matters.
  assign lane0 = byteenable[0];

  // Clear pulses reach the bank only in the committing cycle.
  always_comb begin
    sif.clr = '0;
    if (commit_wr && lane0 && address == status_irq_pkg::OFS_CLEAR) begin
      sif.clr = writedata[status_irq_pkg::NUM_SRC-1:0]; // (R2)
    end
  end

  // Next-state logic for the bus slave, the control registers and the
  // two registered pins.
  always_comb begin
    s_next = s_reg;
    // Waitrequest sits high by default and drops for one answer cycle.
    s_next.wait_req = ~accept;
    if (accept && read) begin
      // Read data are captured at the accept edge and stand through the
      // answer cycle; live bits show the condition at that moment.
      if (address == status_irq_pkg::OFS_LIVE) begin
        s_next.rdata = {{(status_irq_pkg::DATA_W -
          status_irq_pkg::LIVE_W){1'b0}}, live_word}; // (R1)
      end else if (address == status_irq_pkg::OFS_STICKY) begin
        // Latched faults read inverted, so 1 means healthy.
        s_next.rdata = {{(status_irq_pkg::DATA_W -
          status_irq_pkg::NUM_SRC){1'b0}}, ~sif.sticky}; // (R7) (R8)
      end else if (address == status_irq_pkg::OFS_IRQ_EN) begin
        s_next.rdata = {{(status_irq_pkg::DATA_W -
          status_irq_pkg::NUM_SRC){1'b0}}, s_reg.irq_en};
      end else if (address == status_irq_pkg::OFS_MODE) begin
        s_next.rdata = {{(status_irq_pkg::DATA_W -
          status_irq_pkg::MODE_W){1'b0}}, s_reg.mode};
      end else begin
        // Clear register and unmapped addresses read as zero.
        s_next.rdata = status_irq_pkg::RDATA_RESET;
      end
    end
    if (commit_wr && lane0) begin
      if (address == status_irq_pkg::OFS_IRQ_EN) begin
        s_next.irq_en = writedata[status_irq_pkg::NUM_SRC-1:0]; // (R4)
      end else if (address == status_irq_pkg::OFS_MODE) begin
        s_next.mode = status_irq_pkg::sel_mode_t'(
          writedata[status_irq_pkg::MODE_LSB +: status_irq_pkg::MODE_W]);
      end else begin
        // Read-only, clear and unmapped writes leave this state alone.
        s_next.irq_en = s_reg.irq_en;
      end
    end
    // Active-low level that stays low while any enabled latch is set
    // and rises once they are all cleared.
    s_next.irq_n = ~sif.pending; // (R6) (R16) (R18)
    // Lock pin follows the latched lock bits of both PLLs, so a glitch
    // of lock stays visible until software clears it.
    s_next.lock = ~sif.sticky[status_irq_pkg::SRC_PLL1] &
      ~sif.sticky[status_irq_pkg::SRC_PLL2]; // (R14) (R17)
  end

  // State register; the interrupt pin idles released and the lock pin
  // idles low until the first clock after reset shows lock.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg.wait_req <= 1'b1;
      s_reg.rdata <= status_irq_pkg::RDATA_RESET;
      s_reg.irq_en <= status_irq_pkg::IRQ_EN_RESET;
      s_reg.mode <= status_irq_pkg::SEL_MANUAL;
      s_reg.irq_n <= 1'b1;
      s_reg.lock <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Every top-level output comes straight from the state register.
  assign readdata = s_reg.rdata;
  assign waitrequest = s_reg.wait_req;
  assign irq_out_n = s_reg.irq_n;
  assign lock_out = s_reg.lock;

endmodule : status_irq_top

// ---- verification/status_irq_monitor.sv ----
// Watches the register port and the two device pins of the status block.
module status_irq_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [status_irq_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [status_irq_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [status_irq_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic pll1_lock_sense,
  input wire logic pll2_lock_sense,
  input wire logic irq_out_n,
  input wire logic lock_out
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Shadow of the enable register, rebuilt from committed writes.
  logic [status_irq_pkg::NUM_SRC-1:0] en_reg;
  // Cycles since the last committed write, saturating at 15.
  logic [3:0] since_wr_reg;
  // A write takes effect only at the edge that sees waitrequest low.
  logic commit;
  assign commit = write && !waitrequest && byteenable[0];
  // Helper state; pins can only recover after software has acted.
  // Reset counts as such an action: the latches start clean, so the lock
  // pin may rise for a cycle before the first faults are latched.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en_reg <= '0;
      since_wr_reg <= 4'h0;
    end else begin
      if (commit && address == status_irq_pkg::OFS_IRQ_EN) begin
        en_reg <= writedata[status_irq_pkg::NUM_SRC-1:0];
      end
      if (commit) begin
        since_wr_reg <= 4'h0;
      end else if (since_wr_reg != 4'hf) begin
        since_wr_reg <= since_wr_reg + 4'h1;
      end
    end
  end
  a_wait_pulse:
    assert property ((read || write) && waitrequest |=> !waitrequest ##1
      waitrequest) else $error("waitrequest not a single low cycle");
  a_clear_reads_zero:
    assert property (read && waitrequest &&
      address == status_irq_pkg::OFS_CLEAR |=> readdata == 32'h0000_0000)
    else $error("clear register did not read as zero");
  a_lock_drops:
    assert property (!pll1_lock_sense [*3] |-> ##[1:6] !lock_out)
    else $error("lock pin stayed high after first loop lost lock");
  a_lock_rise_cause:
    assert property ($rose(lock_out) |-> since_wr_reg < 4'h6)
    else $error("lock pin rose without a clear write");
  a_irq_on_event:
    assert property (en_reg[3] && !pll2_lock_sense [*3] |-> ##[1:6]
      !irq_out_n) else $error("enabled event raised no interrupt");
  a_irq_release_cause:
    assert property ($rose(irq_out_n) |-> since_wr_reg < 4'h6)
    else $error("interrupt released without a write");
  a_en_zero_quiet:
    assert property (en_reg == '0 && $past(en_reg) == '0 &&
      $past(en_reg, 2) == '0 |-> irq_out_n)
    else $error("interrupt asserted with all enables zero");
  a_irq_level_hold:
    assert property (!irq_out_n && !commit && !$past(commit) |=>
      !irq_out_n)
    else $error("interrupt released with no clear or enable write");
endmodule : status_irq_monitor

bind status_irq_top status_irq_monitor i_monitor (
  .clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest),
  .pll1_lock_sense(pll1_lock_sense), .pll2_lock_sense(pll2_lock_sense),
  .irq_out_n(irq_out_n), .lock_out(lock_out)
);

// ---- verification/condition_source.sv ----
// Model of the clocking core that drives the condition pins.
module condition_source (
  input wire logic clk_sys,
  input wire logic [7:0] want,
  output logic [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Start from the wanted levels so no pin is unknown at time zero.
  initial pins = want;
  // The core moves its lines just after an edge, never at the sample.
  always @(posedge clk_sys) begin
    pins <= want;
  end
endmodule : condition_source

// ---- verification/status_irq_top_test.sv ----
// Bench acting as the host: bus tasks plus a core model for the pins.
module status_irq_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys;
  logic rst;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq_out_n;
  logic lock_out;
  // Wanted pin levels and what the core model presents.
  logic [7:0] want;
  logic [7:0] pins;
  logic [31:0] d;
  int n_fail;
  int num_checks;
  // Mode sweep: mode, pin levels and the live word expected.
  logic [1:0] mode_tab [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
  logic [7:0] pin_tab [5] = '{8'h0e, 8'h1f, 8'h8f, 8'h1f, 8'h6f};
  logic [7:0] live_tab [5] = '{8'h5e, 8'h6f, 8'h5f, 8'h4f, 8'hbf};
  condition_source i_core (.clk_sys(clk_sys), .want(want), .pins(pins));
  status_irq_top i_dut (
    .clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'h1),
    .readdata(readdata), .waitrequest(waitrequest),
    .ref_in0_sense(pins[0]), .ref_in1_sense(pins[1]),
    .pll1_lock_sense(pins[2]), .pll2_lock_sense(pins[3]),
    .holdover_sense(pins[4]), .vco_cal_done_sense(pins[5]),
    .ref_sel_sense(pins[6]), .sel_busy_sense(pins[7]),
    .irq_out_n(irq_out_n), .lock_out(lock_out)
  );
  // Prints the verdict and ends the run.
  task automatic conclude();
    if (n_fail == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // Counts a comparison and reports a mismatch at once.
  task automatic compare(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : compare
  // One bus cycle; the request stands until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) n_fail++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  // Moves the pins and waits past synchroniser, sticky and pin stages.
  task automatic set_pins(input logic [7:0] v);
    want <= v;
    repeat (8) @(posedge clk_sys);
  endtask : set_pins
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Generous bound: the sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    want = 8'h0f;
    n_fail = 0;
    num_checks = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    set_pins(8'h0f);
    bus(0, status_irq_pkg::OFS_LIVE, 0, d);
    compare("live", 32'h7f, d);
    compare("lock after reset", 0, lock_out);
    compare("irq masked", 1, irq_out_n);
    bus(0, status_irq_pkg::OFS_IRQ_EN, 0, d);
    compare("enable reset", 0, d);
    bus(1, status_irq_pkg::OFS_CLEAR, 32'h3f, d);
    bus(0, status_irq_pkg::OFS_STICKY, 0, d);
    compare("sticky cleared", 32'h3f, d);
    compare("lock clean", 1, lock_out);
    // Software enables both lock-loss sources together.
    bus(1, status_irq_pkg::OFS_IRQ_EN, 32'h0c, d);
    bus(0, status_irq_pkg::OFS_IRQ_EN, 0, d);
    compare("enable rw", 32'h0c, d);
    set_pins(8'h07);
    set_pins(8'h0f);
    bus(0, status_irq_pkg::OFS_STICKY, 0, d);
    compare("sticky pll2", 32'h37, d);
    compare("lock pll2", 0, lock_out);
    compare("irq pll2", 0, irq_out_n);
    bus(0, status_irq_pkg::OFS_LIVE, 0, d);
    compare("live recovered", 32'h7f, d);
    set_pins(8'h0d);
    bus(1, status_irq_pkg::OFS_CLEAR, 32'h0a, d);
    bus(0, status_irq_pkg::OFS_STICKY, 0, d);
    compare("sticky persists", 32'h3d, d);
    compare("irq masked src", 1, irq_out_n);
    bus(1, status_irq_pkg::OFS_IRQ_EN, 32'h0e, d);
    bus(0, status_irq_pkg::OFS_LIVE, 0, d);
    compare("live ref1 lost", 32'h7d, d);
    compare("irq unmasked", 0, irq_out_n);
    set_pins(8'h0f);
    bus(1, status_irq_pkg::OFS_CLEAR, 32'h02, d);
    bus(0, status_irq_pkg::OFS_STICKY, 0, d);
    compare("sticky clean", 32'h3f, d);
    compare("irq released", 1, irq_out_n);
    bus(1, status_irq_pkg::OFS_IRQ_EN, 32'h00, d);
    set_pins(8'h0b);
    set_pins(8'h0f);
    bus(0, status_irq_pkg::OFS_STICKY, 0, d);
    compare("sticky pll1", 32'h3b, d);
    compare("irq disabled", 1, irq_out_n);
    compare("lock pll1", 0, lock_out);
    for (int i = 0; i < 5; i++) begin
      bus(1, status_irq_pkg::OFS_MODE, {30'h0, mode_tab[i]}, d);
      bus(0, status_irq_pkg::OFS_MODE, 0, d);
      compare("mode", {30'h0, mode_tab[i]}, d);
      set_pins(pin_tab[i]);
      bus(0, status_irq_pkg::OFS_LIVE, 0, d);
      compare("live mode", {24'h0, live_tab[i]}, d);
    end
    bus(0, 5'h14, 0, d);
    compare("unmapped", 0, d);
    bus(0, status_irq_pkg::OFS_CLEAR, 0, d);
    compare("clear reads", 0, d);
    conclude();
  end
endmodule : status_irq_top_test
